// ### reset_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the reset controller
`ifndef RESET_CTRL_REGS_SVH
`define RESET_CTRL_REGS_SVH

`define OFS_COMMAND 8'h00
`define OFS_STATUS 8'h04
`define OFS_MODE 8'h08
`define OFS_IRQ_STATUS 8'h0c
`define OFS_IRQ_MASK 8'h10

`define CMD_CORE_BIT 0
`define CMD_PERIPH_BIT 2
`define CMD_EXT_BIT 3

`define STAT_PIN_BIT 0
`define STAT_CAUSE_LO 8
`define STAT_CAUSE_HI 10
`define STAT_PEND_BIT 17

`define MODE_LEN_LO 8
`define MODE_LEN_HI 11
`define MODE_CORE_ONLY_BIT 16
`define MODE_RESET_LEN 4'h0
`define MODE_RESET_CORE_ONLY 1'b0

`define CAUSE_GENERAL 3'h0
`define CAUSE_WAKEUP 3'h1
`define CAUSE_WATCHDOG 3'h2
`define CAUSE_SOFTWARE 3'h3
`define CAUSE_USER 3'h4

`define STATUS_RESET 32'h0000_0001
`define WDT_TICK_LAST 2'h2
`define PIN_CNT_W 17
`define PIN_CNT_ONE 17'h00001
`define PIN_SHIFT_ONE 5'h01

`define IRQ_W 3
`define IRQ_SW_BIT 0
`define IRQ_WDT_BIT 1
`define IRQ_USER_BIT 2

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### reset_ctrl_pkg.sv
// Types shared by the reset controller modules
`default_nettype none
package reset_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SW = 2'b01,
        ST_WDT = 2'b10
    } rst_state_t;

    typedef struct packed {
        logic core;
        logic periph;
        logic ext;
    } sw_cmd_t;

    typedef struct packed {
        logic [3:0] pin_len;
        logic core_only;
    } rst_mode_t;
endpackage : reset_ctrl_pkg
`default_nettype wire

// ### slow_clock_tick.sv
// Synchroniser and rising-edge detector that turns the slow clock into main-clock ticks
`default_nettype none
module slow_clock_tick (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    input wire logic slow_clock,
    output logic tick
);
    logic sync_a;
    logic sync_b;
    logic sync_c;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            tick <= 1'b0;
        end else if (aclken) begin
            sync_a <= slow_clock;
            sync_b <= sync_a;
            sync_c <= sync_b;
            tick <= sync_b & ~sync_c;
        end
    end
endmodule : slow_clock_tick
`default_nettype wire

// ### reset_ctrl_sw_watchdog_reset.sv
// Software and watchdog reset sequencer with AXI4-Lite registers
//
// Local design decision: the AXI4-Lite slave port.
`include "reset_ctrl_regs.svh"
`default_nettype none
module reset_ctrl_sw_watchdog_reset (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    input wire logic slow_clock,
    input wire logic watchdog_fault,
    input wire logic wakeup_powerup,
    input wire logic nrst_i,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic core_reset_n,
    output logic periph_reset_n,
    output logic nrst_o,
    output logic nrst_oe_n,
    output logic irq
);
    import reset_ctrl_pkg::*;

    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    rst_state_t state;
    rst_state_t next_state;
    rst_mode_t mode;
    sw_cmd_t sw_cmd;
    logic wd_core_only;
    logic [2:0] reset_cause;
    logic [2:0] next_cause;
    logic pending;
    logic pin_level;
    logic powerup_done;
    logic [`PIN_CNT_W-1:0] pin_count;
    logic [`PIN_CNT_W-1:0] next_pin_count;
    logic [1:0] wdt_ticks;
    logic [`IRQ_W-1:0] irq_status;
    logic [`IRQ_W-1:0] next_irq_status;
    logic [`IRQ_W-1:0] irq_mask;
    logic nrst_prev;
    logic self_mask;
    logic tick;
    logic [31:0] status_word;
    logic [31:0] mode_word;

    // ****************************************************
    // Slow clock tick
    // ****************************************************
    slow_clock_tick u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .aclken(aclken),
        .slow_clock(slow_clock),
        .tick(tick)
    );

    // ****************************************************
    // Register decode
    // ****************************************************
    wire write_go = !awready && !wready && !bvalid;
    wire wr_cmd = write_go && aw_addr == `OFS_COMMAND && w_strb[0];
    wire wr_mode = write_go && aw_addr == `OFS_MODE;
    wire wr_istat = write_go && aw_addr == `OFS_IRQ_STATUS && w_strb[0];
    wire wr_imask = write_go && aw_addr == `OFS_IRQ_MASK && w_strb[0];
    wire wr_mapped = aw_addr == `OFS_COMMAND || aw_addr == `OFS_MODE
        || aw_addr == `OFS_IRQ_STATUS || aw_addr == `OFS_IRQ_MASK;
    wire rd_mapped = araddr == `OFS_COMMAND || araddr == `OFS_STATUS || araddr == `OFS_MODE
        || araddr == `OFS_IRQ_STATUS || araddr == `OFS_IRQ_MASK;
    wire [31:0] rd_word = araddr == `OFS_STATUS ? status_word
        : araddr == `OFS_MODE ? mode_word
        : araddr == `OFS_IRQ_STATUS ? {29'h0, irq_status}
        : araddr == `OFS_IRQ_MASK ? {29'h0, irq_mask}
        : 32'h0;
    wire sw_cmd_t cmd_in = '{core: w_data[`CMD_CORE_BIT],
        periph: w_data[`CMD_PERIPH_BIT], ext: w_data[`CMD_EXT_BIT]};

    // ****************************************************
    // Sequencer decode
    // ****************************************************
    // Watchdog fault has priority over a command in the same cycle
    wire wdt_enter = watchdog_fault && state != ST_WDT;
    wire cmd_accept = wr_cmd && !pending && state == ST_IDLE && !watchdog_fault;
    wire pin_busy = pin_count != '0;
    wire pin_last = pin_count == `PIN_CNT_ONE;
    wire [`PIN_CNT_W-1:0] pin_load = `PIN_CNT_ONE << ({1'b0, mode.pin_len} + `PIN_SHIFT_ONE);
    wire sw_exit = state == ST_SW && tick && (!pin_busy || pin_last);
    wire wdt_exit = state == ST_WDT && tick && wdt_ticks == `WDT_TICK_LAST;
    wire sw_left = state == ST_SW && next_state != ST_SW;
    wire pin_start = (cmd_accept && cmd_in.ext) || (wdt_enter && !mode.core_only);
    wire user_event = nrst_prev && !nrst_i && !self_mask && !pin_busy;
    wire sw_cmd_t next_cmd = cmd_accept ? cmd_in : sw_cmd;
    wire next_core_only = wdt_enter ? mode.core_only : wd_core_only;
    wire next_core_assert = (next_state == ST_SW && next_cmd.core)
        || next_state == ST_WDT;
    wire next_periph_assert = (next_state == ST_SW && next_cmd.periph)
        || (next_state == ST_WDT && !next_core_only);
    wire [`IRQ_W-1:0] irq_events = {user_event, wdt_exit, sw_left};
    wire [`IRQ_W-1:0] irq_clear = wr_istat ? w_data[`IRQ_W-1:0] : '0;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (wdt_enter) begin
                    next_state = ST_WDT;
                end else if (cmd_accept) begin
                    next_state = ST_SW;
                end
            end
            ST_SW: begin
                if (wdt_enter) begin
                    next_state = ST_WDT;
                end else if (sw_exit) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WDT: begin
                if (wdt_exit) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        next_pin_count = pin_count;
        if (pin_start) begin
            next_pin_count = pin_load;
        end else if (tick && pin_busy) begin
            next_pin_count = pin_count - `PIN_CNT_ONE;
        end
    end

    always_comb begin
        next_cause = reset_cause;
        if (!powerup_done) begin
            next_cause = wakeup_powerup ? `CAUSE_WAKEUP : `CAUSE_GENERAL;
        end else if (wdt_enter) begin
            next_cause = `CAUSE_WATCHDOG;
        end else if (cmd_accept && cmd_in.core) begin
            next_cause = `CAUSE_SOFTWARE;
        end else if (user_event) begin
            next_cause = `CAUSE_USER;
        end
    end

    always_comb begin
        status_word = 32'h0;
        status_word[`STAT_PIN_BIT] = pin_level;
        status_word[`STAT_CAUSE_HI:`STAT_CAUSE_LO] = reset_cause;
        status_word[`STAT_PEND_BIT] = pending;
        mode_word = 32'h0;
        mode_word[`MODE_LEN_HI:`MODE_LEN_LO] = mode.pin_len;
        mode_word[`MODE_CORE_ONLY_BIT] = mode.core_only;
    end

    // A new event wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < `IRQ_W; gi++) begin : g_irq
            assign next_irq_status[gi] = irq_events[gi] | (irq_status[gi] & ~irq_clear[gi]);
        end
    endgenerate

    // ****************************************************
    // AXI4-Lite slave
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (aclken) begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (write_go) begin
                bvalid <= 1'b1;
                bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `RESP_OKAY;
        end else if (aclken) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ****************************************************
    // Control registers
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= '{pin_len: `MODE_RESET_LEN, core_only: `MODE_RESET_CORE_ONLY};
            irq_mask <= '0;
            irq_status <= '0;
            irq <= 1'b0;
        end else if (aclken) begin
            if (wr_mode && w_strb[1]) begin
                mode.pin_len <= w_data[`MODE_LEN_HI:`MODE_LEN_LO];
            end
            if (wr_mode && w_strb[2]) begin
                mode.core_only <= w_data[`MODE_CORE_ONLY_BIT];
            end
            if (wr_imask) begin
                irq_mask <= w_data[`IRQ_W-1:0];
            end
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & (wr_imask ? w_data[`IRQ_W-1:0] : irq_mask));
        end
    end

    // ****************************************************
    // Reset sequencer
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            sw_cmd <= '0;
            wd_core_only <= 1'b0;
            wdt_ticks <= 2'h0;
            pending <= 1'b0;
            pin_count <= '0;
        end else if (aclken) begin
            state <= next_state;
            sw_cmd <= next_cmd;
            wd_core_only <= next_core_only;
            wdt_ticks <= wdt_enter ? 2'h0 : (state == ST_WDT && tick) ? wdt_ticks + 2'h1
                : wdt_ticks;
            pending <= next_state == ST_SW;
            pin_count <= next_pin_count;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_reset_n <= 1'b1;
            periph_reset_n <= 1'b1;
            nrst_o <= 1'b0;
            nrst_oe_n <= 1'b1;
            reset_cause <= `CAUSE_GENERAL;
            pin_level <= 1'(`STATUS_RESET >> `STAT_PIN_BIT);
            powerup_done <= 1'b0;
            nrst_prev <= 1'b1;
            self_mask <= 1'b0;
        end else if (aclken) begin
            core_reset_n <= !next_core_assert;
            periph_reset_n <= !next_periph_assert;
            nrst_o <= 1'b0;
            nrst_oe_n <= next_pin_count == '0;
            reset_cause <= next_cause;
            pin_level <= nrst_i;
            powerup_done <= 1'b1;
            nrst_prev <= nrst_i;
            // Mask stays until the pin is seen high again after our own drive
            self_mask <= pin_busy || (self_mask && !nrst_i);
        end
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    sequence s_cmd_core;
        cmd_accept && cmd_in.core && aclken;
    endsequence

    sequence s_wdt_full;
        wdt_enter && !mode.core_only && aclken;
    endsequence

    property p_cmd_asserts_core;
        @(posedge aclk) disable iff (!aresetn)
        s_cmd_core |=> !core_reset_n && pending;
    endproperty
    a_cmd_asserts_core: assert property (p_cmd_asserts_core)
        else $error("core reset not asserted after command");

    property p_release_on_tick;
        @(posedge aclk) disable iff (!aresetn)
        $rose(core_reset_n) |-> $past(tick);
    endproperty
    a_release_on_tick: assert property (p_release_on_tick)
        else $error("core reset released off a slow tick");

    property p_ext_drives_pin;
        @(posedge aclk) disable iff (!aresetn)
        cmd_accept && cmd_in.ext && aclken |=> !nrst_oe_n && pin_count == $past(pin_load);
    endproperty
    a_ext_drives_pin: assert property (p_ext_drives_pin)
        else $error("pin not driven for programmed length");

    property p_no_user_while_driving;
        @(posedge aclk) disable iff (!aresetn)
        (pin_busy || self_mask) |-> !user_event;
    endproperty
    a_no_user_while_driving: assert property (p_no_user_while_driving)
        else $error("own pin drive taken as user reset");

    property p_cause_only_core;
        @(posedge aclk) disable iff (!aresetn)
        cmd_accept && !cmd_in.core && !user_event && aclken && powerup_done |=> $stable(reset_cause);
    endproperty
    a_cause_only_core: assert property (p_cause_only_core)
        else $error("cause changed by command without core request");

    property p_pending_clears;
        @(posedge aclk) disable iff (!aresetn)
        sw_left && aclken |=> !pending ##0 state != ST_SW;
    endproperty
    a_pending_clears: assert property (p_pending_clears)
        else $error("pending not cleared on exit");

    property p_ignore_when_pending;
        @(posedge aclk) disable iff (!aresetn)
        wr_cmd && pending && aclken |=> $stable(sw_cmd) && (state != ST_IDLE || $past(sw_exit));
    endproperty
    a_ignore_when_pending: assert property (p_ignore_when_pending)
        else $error("command taken while pending");

    property p_wdt_three_ticks;
        @(posedge aclk) disable iff (!aresetn)
        $fell(state == ST_WDT) |-> $past(tick) && $past(wdt_ticks) == `WDT_TICK_LAST;
    endproperty
    a_wdt_three_ticks: assert property (p_wdt_three_ticks)
        else $error("watchdog state length wrong");

    property p_wdt_full_reset;
        @(posedge aclk) disable iff (!aresetn)
        s_wdt_full |=> !core_reset_n && !periph_reset_n && !nrst_oe_n;
    endproperty
    a_wdt_full_reset: assert property (p_wdt_full_reset)
        else $error("watchdog reset incomplete");

    property p_wdt_core_only;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_WDT && wd_core_only |-> !core_reset_n && periph_reset_n;
    endproperty
    a_wdt_core_only: assert property (p_wdt_core_only)
        else $error("core-only watchdog reset touched peripherals");

    property p_status_after_reset;
        @(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> pin_level && reset_cause == `CAUSE_GENERAL && !pending;
    endproperty
    a_status_after_reset: assert property (p_status_after_reset)
        else $error("status reset value wrong");
endmodule : reset_ctrl_sw_watchdog_reset
`default_nettype wire

// ### reset_far_side.sv
// Far-side model: open-drain external reset line with pull-up and a user push-button
`default_nettype none
module reset_far_side (
    input wire logic nrst_o,
    input wire logic nrst_oe_n,
    input wire logic user_press,
    output logic nrst_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Line resolution
    // ****************
    // Pull-up wins unless the block drives low or the button is held
    assign nrst_i = ((nrst_oe_n == 1'b0 && nrst_o == 1'b0) || user_press) ? 1'b0 : 1'b1;
endmodule : reset_far_side
`default_nettype wire

// ### reset_ctrl_sw_watchdog_reset_test.sv
// Self-checking bench of the software and watchdog reset sequencer
`include "reset_ctrl_regs.svh"
`default_nettype none
module reset_ctrl_sw_watchdog_reset_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SP = 16;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic aclken = 1'b1;
    logic [3:0] slow_cnt = 4'h0;
    logic watchdog_fault = 1'b0;
    logic wakeup_powerup = 1'b0;
    logic user_press = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, nrst_i, irq;
    logic core_reset_n, periph_reset_n, nrst_o, nrst_oe_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] outs;
    int cyc = 0;
    int failures = 0;
    int checked = 0;
    assign outs = {nrst_oe_n, periph_reset_n, core_reset_n};
    // ****************
    // Clocks and instances
    // ****************
    initial begin
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        slow_cnt <= slow_cnt + 4'h1;
        cyc <= cyc + 1;
    end
    reset_ctrl_sw_watchdog_reset reset_ctrl_sw_watchdog_reset_inst (
        .aclk(aclk), .aresetn(aresetn), .aclken(aclken), .slow_clock(slow_cnt[3]),
        .watchdog_fault(watchdog_fault), .wakeup_powerup(wakeup_powerup), .nrst_i(nrst_i),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
        .core_reset_n(core_reset_n), .periph_reset_n(periph_reset_n), .nrst_o(nrst_o),
        .nrst_oe_n(nrst_oe_n), .irq(irq)
    );
    reset_far_side reset_far_side_inst (
        .nrst_o(nrst_o), .nrst_oe_n(nrst_oe_n), .user_press(user_press), .nrst_i(nrst_i)
    );
    // ****************
    // Reporting and bus tasks
    // ****************
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic in_range(input string what, input int lo, input int hi, input int got);
        checked++;
        if (got < lo || got > hi) begin
            failures++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : in_range
    task automatic hang(input string what);
        failures++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        end_sim();
    endtask : hang
    function automatic logic [31:0] st(input logic p, input logic [2:0] c, input logic pin);
        return {14'h0, p, 6'h0, c, 7'h0, pin};
    endfunction : st
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 40) hang("write response");
        cmp("write response", {30'h0, er}, {30'h0, bresp});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
            input string what);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 40) hang("read response");
        cmp(what, e, rdata);
        cmp("read response", {30'h0, er}, {30'h0, rresp});
    endtask : rd
    task automatic wait_outs(input logic [2:0] m, input logic [2:0] e);
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge aclk);
            if ((outs & m) === e) break;
        end
        if (n == 300) hang("reset outputs");
    endtask : wait_outs
    // ****************
    // Scenarios
    // ****************
    task automatic t_after_reset(input logic wake);
        rd(`OFS_STATUS, st(1'b0, wake ? `CAUSE_WAKEUP : `CAUSE_GENERAL, 1'b1), `RESP_OKAY,
            "status after reset");
        rd(`OFS_MODE, 32'h0, `RESP_OKAY, "mode after reset");
        rd(`OFS_COMMAND, 32'h0, `RESP_OKAY, "command readback");
        rd(8'h14, 32'h0, `RESP_SLVERR, "unmapped read");
        wr(8'h14, 32'hffff_ffff, `RESP_SLVERR);
        cmp("idle reset outputs", 32'h7, {29'h0, outs});
    endtask : t_after_reset
    task automatic t_sw_full;
        int t0;
        logic [3:0] ph;
        wr(`OFS_MODE, 32'h0000_0100, `RESP_OKAY);
        wr(`OFS_COMMAND, 32'h0000_0009, `RESP_OKAY);
        t0 = cyc;
        cmp("resets after command", 32'h2, {29'h0, outs});
        rd(`OFS_STATUS, st(1'b1, `CAUSE_SOFTWARE, 1'b0), `RESP_OKAY, "status pending");
        wr(`OFS_COMMAND, 32'h0000_0004, `RESP_OKAY);
        cmp("periph while pending", 32'h1, {31'h0, periph_reset_n});
        wait_outs(3'h7, 3'h7);
        ph = slow_cnt - 4'h8;
        in_range("pin drive cycles", 3 * SP, 4 * SP + 4, cyc - t0);
        in_range("release after slow edge", 3, 7, int'(ph));
        rd(`OFS_STATUS, st(1'b0, `CAUSE_SOFTWARE, 1'b1), `RESP_OKAY, "status done");
        rd(`OFS_IRQ_STATUS, 32'h1, `RESP_OKAY, "irq status after sw");
    endtask : t_sw_full
    task automatic t_wdt(input logic co);
        int t0;
        wr(`OFS_MODE, {15'h0, co, 16'h0000}, `RESP_OKAY);
        wr(`OFS_IRQ_STATUS, 32'h7, `RESP_OKAY);
        watchdog_fault <= 1'b1;
        @(posedge aclk);
        watchdog_fault <= 1'b0;
        t0 = cyc;
        wait_outs(3'h1, 3'h0);
        cmp("watchdog reset outputs", co ? 32'h6 : 32'h0, {29'h0, outs});
        wait_outs(3'h1, 3'h1);
        in_range("watchdog state cycles", 2 * SP, 3 * SP + 4, cyc - t0);
        cmp("periph with core release", 32'h1, {31'h0, periph_reset_n});
        wait_outs(3'h7, 3'h7);
        rd(`OFS_STATUS, st(1'b0, `CAUSE_WATCHDOG, 1'b1), `RESP_OKAY, "status watchdog");
        rd(`OFS_IRQ_STATUS, 32'h2, `RESP_OKAY, "irq status watchdog");
        cmp("irq masked", 32'h0, {31'h0, irq});
        wr(`OFS_IRQ_MASK, 32'h2, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        cmp("irq unmasked", 32'h1, {31'h0, irq});
        wr(`OFS_IRQ_STATUS, 32'h2, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        cmp("irq cleared", 32'h0, {31'h0, irq});
        wr(`OFS_IRQ_MASK, 32'h0, `RESP_OKAY);
    endtask : t_wdt
    task automatic t_sw_one(input logic [31:0] c, input logic [2:0] e);
        wr(`OFS_COMMAND, c, `RESP_OKAY);
        cmp("partial command outputs", {29'h0, e}, {29'h0, outs});
        rd(`OFS_STATUS, st(1'b1, `CAUSE_WATCHDOG, e[2]), `RESP_OKAY, "cause kept");
        wait_outs(3'h7, 3'h7);
    endtask : t_sw_one
    task automatic t_user;
        wr(`OFS_IRQ_STATUS, 32'h7, `RESP_OKAY);
        user_press <= 1'b1;
        repeat (40) @(posedge aclk);
        user_press <= 1'b0;
        wait_outs(3'h7, 3'h7);
        repeat (10) @(posedge aclk);
        rd(`OFS_STATUS, st(1'b0, `CAUSE_USER, 1'b1), `RESP_OKAY, "status user");
        rd(`OFS_IRQ_STATUS, 32'h4, `RESP_OKAY, "irq status user");
    endtask : t_user
    task automatic t_freeze;
        aclken <= 1'b0;
        @(posedge aclk);
        watchdog_fault <= 1'b1;
        @(posedge aclk);
        watchdog_fault <= 1'b0;
        repeat (40) @(posedge aclk);
        cmp("frozen reset outputs", 32'h7, {29'h0, outs});
        aclken <= 1'b1;
        @(posedge aclk);
        rd(`OFS_STATUS, st(1'b0, `CAUSE_USER, 1'b1), `RESP_OKAY, "status after freeze");
    endtask : t_freeze
    task automatic t_wake;
        aresetn <= 1'b0;
        wakeup_powerup <= 1'b1;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_after_reset(1'b1);
    endtask : t_wake
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_after_reset(1'b0);
        t_sw_full();
        t_wdt(1'b0);
        t_sw_one(32'h0000_0004, 3'h5);
        t_sw_one(32'h0000_0008, 3'h3);
        t_wdt(1'b1);
        t_user();
        t_freeze();
        t_wake();
        end_sim();
    end
endmodule : reset_ctrl_sw_watchdog_reset_test
`default_nettype wire
